/* hcc_console.sv */
/*
 * hcc_console: console controller with key register, io flags, rom/ram
 * memory section, display scanner and keyboard scanner.
 * assumes bus commands are one-cycle pulses from logic on clk; key
 * column lines and strobe arrive from pins and are synchronised here.
 */
`timescale 1ns/1ps
module hcc_console
	import hcc_pkg::*;
#(
	parameter int DP_CYC   = DP_HOLD_CYC,    // decimal point hold cycles
	parameter int STEP_CYC = SCAN_STEP_CYC,  // cycles per scan step
	parameter int DEB_CYC  = DEBOUNCE_CYC    // key settle cycles, under STEP_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// io bus commands (one-cycle pulses)
	input  wire logic        io_read_a,      // read_input_a
	input  wire logic        io_read_c,      // read_input_c
	input  wire logic        io_write_c,     // write_output_c
	input  wire logic [1:0]  io_flag_op,     // flag op with command
	output logic [15:0]      io_data_in,     // data to host accumulator
	output logic             io_data_valid,  // io_data_in valid pulse
	output logic             io_busy,        // busy flag
	output logic             io_done,        // done flag
	output logic             io_int_req,     // interrupt request
	// memory bus
	input  wire logic        mem_start,      // operation start pulse
	input  wire logic [14:0] mem_addr,       // word address
	input  wire logic        mem_read,       // read op
	input  wire logic        mem_write,      // write op
	input  wire logic        mem_refresh,    // refresh op
	input  wire logic [15:0] mem_wdata,      // write data
	input  wire logic        mem_end,        // operation end pulse
	output logic [15:0]      mem_rdata,      // read data
	output logic             mem_rdata_oe,   // read data drive enable
	output logic             memory_inhibit_line, // keeps other memory off
	// display and keyboard
	output logic [2:0]       disp_scan,      // latched scan number
	output logic [6:0]       disp_segments,  // latched segment pattern
	output logic [5:0]       disp_cell,      // latched cell enable
	output logic             disp_point,     // decimal point
	output logic [4:0]       key_rows,       // keyboard row drive
	input  wire logic [3:0]  key_columns_pin,// column lines, one hot
	input  wire logic        key_strobe_pin  // any column active
);
	// ---------------------------------------------------------------
	// storage
	// ---------------------------------------------------------------
	logic [15:0] rom_mem [ROM_WORDS];   // console program rom
	logic [15:0] ram_mem [RAM_WORDS];   // static overlay
	logic [7:0]  addr_reg;              // latched low address
	logic        op_active_reg;         // cpu operation in progress
	logic        op_read_reg;           // latched read intent
	logic        op_write_reg;          // latched write intent
	logic        op_hit_reg;            // address in section
	logic [15:0] disp_word_reg;         // fetched display word
	logic [4:0]  key_code_reg;          // key function register
	logic [2:0]  scan_reg;              // current scan step
	logic [15:0] step_cnt_reg;          // scan step timer
	logic        step_en;               // one-cycle step enable
	logic [22:0] dp_cnt_reg;            // decimal point timer
	logic [3:0]  col_s1_reg, col_s2_reg;// column synchroniser
	logic        stb_s1_reg, stb_s2_reg;// strobe synchroniser
	logic        key_press;             // debounced press pulse
	logic [1:0]  col_code;              // encoded column
	logic [2:0]  group;                 // selected octal group

	// rom contents: console program is loaded by the build; blank here
	initial begin
		for (int i = 0; i < ROM_WORDS; i++) begin
			rom_mem[i] = 16'h0000;
		end
	end

	// ---------------------------------------------------------------
	// memory bus
	// ---------------------------------------------------------------
	// latch address and operation type at start; refresh is not decoded
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			addr_reg      <= 8'h00;
			op_active_reg <= 1'b0;
			op_read_reg   <= 1'b0;
			op_write_reg  <= 1'b0;
			op_hit_reg    <= 1'b0;
		end else if (mem_start && !mem_refresh) begin
			addr_reg      <= mem_addr[7:0];
			op_active_reg <= 1'b1;
			op_read_reg   <= mem_read;
			op_write_reg  <= mem_write;
			op_hit_reg    <= (mem_addr >= MEM_BASE) && (mem_addr <= MEM_TOP);
		end else if (mem_end) begin
			op_active_reg <= 1'b0;
			op_read_reg   <= 1'b0;
			op_write_reg  <= 1'b0;
			op_hit_reg    <= 1'b0;
		end
	end

	// read path: ram overlays rom in 160-177, else rom word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mem_rdata           <= 16'h0000;
			mem_rdata_oe        <= 1'b0;
			memory_inhibit_line <= 1'b0;
		end else if (op_active_reg && op_read_reg && op_hit_reg) begin
			if (addr_reg >= RAM_LO && addr_reg <= RAM_HI) begin
				mem_rdata <= rom_mem[addr_reg] | ram_mem[addr_reg[3:0]];
			end else begin
				mem_rdata <= rom_mem[addr_reg];
			end
			mem_rdata_oe        <= 1'b1;
			memory_inhibit_line <= 1'b1;
		end else begin
			mem_rdata           <= 16'h0000;
			mem_rdata_oe        <= 1'b0;
			memory_inhibit_line <= 1'b0;
		end
	end

	// write path: only the overlay stores; refresh never reaches here
	always_ff @(posedge clk) begin
		if (op_active_reg && op_write_reg && op_hit_reg && mem_end
				&& addr_reg >= RAM_LO && addr_reg <= RAM_HI) begin
			ram_mem[addr_reg[3:0]] <= mem_wdata;
		end
	end

	// ---------------------------------------------------------------
	// display scanner
	// ---------------------------------------------------------------
	// step timer producing one enable per scan step
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			step_cnt_reg <= 16'h0000;
			step_en      <= 1'b0;
		end else if (step_cnt_reg == 16'(STEP_CYC - 1)) begin
			step_cnt_reg <= 16'h0000;
			step_en      <= 1'b1;
		end else begin
			step_cnt_reg <= step_cnt_reg + 16'h0001;
			step_en      <= 1'b0;
		end
	end

	// scan number wraps after six steps
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scan_reg <= 3'h0;
		end else if (step_en) begin
			scan_reg <= (scan_reg == 3'(SCAN_STEPS - 1)) ? 3'h0 : scan_reg + 3'h1;
		end
	end

	// display word fetch, only while cpu leaves memory idle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			disp_word_reg <= 16'h0000;
		end else if (!op_active_reg && !mem_start) begin
			disp_word_reg <= rom_mem[DISP_OFS] | ram_mem[DISP_OFS[3:0]];
		end
	end

	// octal group: scan 0 is the leftmost digit (bit 15 alone)
	always_comb begin
		unique case (scan_reg)
			3'h0:    group = {2'h0, disp_word_reg[15]};
			3'h1:    group = disp_word_reg[14:12];
			3'h2:    group = disp_word_reg[11:9];
			3'h3:    group = disp_word_reg[8:6];
			3'h4:    group = disp_word_reg[5:3];
			3'h5:    group = disp_word_reg[2:0];
			default: group = 3'h0;
		endcase
	end

	// octal to seven segment, bits gfedcba
	function automatic logic [6:0] seg_of(input logic [2:0] d);
		unique case (d)
			3'h0: seg_of = 7'h3F;
			3'h1: seg_of = 7'h06;
			3'h2: seg_of = 7'h5B;
			3'h3: seg_of = 7'h4F;
			3'h4: seg_of = 7'h66;
			3'h5: seg_of = 7'h6D;
			3'h6: seg_of = 7'h7D;
			3'h7: seg_of = 7'h07;
		endcase
	endfunction

	// latch scan number and decoded group into the driver
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			disp_scan     <= 3'h0;
			disp_segments <= 7'h00;
			disp_cell     <= 6'h00;
			key_rows      <= 5'h00;
		end else if (step_en) begin
			disp_scan     <= scan_reg;
			disp_segments <= seg_of(group);
			disp_cell     <= 6'(6'h01 << scan_reg);
			key_rows      <= (scan_reg < 3'(KEY_ROWS)) ? 5'(5'h01 << scan_reg) : 5'h00;
		end
	end

	// decimal point right of last digit, held for a while per write command
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dp_cnt_reg <= 23'h0;
			disp_point <= 1'b0;
		end else if (io_write_c) begin
			dp_cnt_reg <= 23'(DP_CYC);
			disp_point <= 1'b1;
		end else if (dp_cnt_reg != 23'h0) begin
			dp_cnt_reg <= dp_cnt_reg - 23'h1;
			disp_point <= (dp_cnt_reg != 23'h1);
		end
	end

	// ---------------------------------------------------------------
	// keyboard
	// ---------------------------------------------------------------
	// pin synchronisers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			col_s1_reg <= 4'h0;
			col_s2_reg <= 4'h0;
			stb_s1_reg <= 1'b0;
			stb_s2_reg <= 1'b0;
		end else begin
			col_s1_reg <= key_columns_pin;
			col_s2_reg <= col_s1_reg;
			stb_s1_reg <= key_strobe_pin;
			stb_s2_reg <= stb_s1_reg;
		end
	end

	// column encoder
	always_comb begin
		if (col_s2_reg[3]) begin
			col_code = 2'h3;
		end else if (col_s2_reg[2]) begin
			col_code = 2'h2;
		end else if (col_s2_reg[1]) begin
			col_code = 2'h1;
		end else begin
			col_code = 2'h0;
		end
	end

	// settle time must end inside the row step that raised the strobe
	hcc_debounce #(.SETTLE_CYC(DEB_CYC)) u_debounce (
		.clk        (clk),
		.rst_n      (rst_n),
		.strobe_in  (stb_s2_reg),
		.press_pulse(key_press)
	);

	// key function register: driven row's scan number over column code;
	// scan_reg has already moved on while that row is driven
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			key_code_reg <= 5'h00;
		end else if (key_press) begin
			key_code_reg <= {disp_scan, col_code};
		end
	end

	// ---------------------------------------------------------------
	// io flags and data
	// ---------------------------------------------------------------
	// busy/done; a key press setting done wins over a same-cycle clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			io_busy <= 1'b0;
			io_done <= 1'b0;
		end else begin
			if (io_read_a || io_read_c || io_write_c) begin
				unique case (io_flag_op)
					FLAG_START: begin
						io_busy <= 1'b1;
						io_done <= 1'b0;
					end
					FLAG_CLEAR: begin
						io_busy <= 1'b0;
						io_done <= 1'b0;
					end
					FLAG_PULSE: io_done <= 1'b0;
					FLAG_NONE:  ;
				endcase
			end
			if (key_press) begin
				io_done <= 1'b1;
			end
		end
	end

	// interrupt request follows a new key code
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			io_int_req <= 1'b0;
		end else if (key_press) begin
			io_int_req <= 1'b1;
		end else if ((io_read_a || io_read_c || io_write_c) && io_flag_op != FLAG_NONE) begin
			io_int_req <= 1'b0;
		end
	end

	// input data: switches word or key code; ac bit 0 is msb
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			io_data_in    <= 16'h0000;
			io_data_valid <= 1'b0;
		end else if (io_read_a) begin
			io_data_in    <= rom_mem[SWITCH_OFS] | ram_mem[SWITCH_OFS[3:0]];
			io_data_valid <= 1'b1;
		end else if (io_read_c) begin
			io_data_in    <= {3'h0, key_code_reg, 8'h00};
			io_data_valid <= 1'b1;
		end else begin
			io_data_valid <= 1'b0;
		end
	end
endmodule // hcc_console

/* hcc_pkg.sv */
/*
 * hcc_pkg: constants shared by the console controller and its key debouncer.
 * assumes a 40 MHz single clock; all scan rates are derived enables.
 */
package hcc_pkg;
	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ           = 40000000;               // system clock rate
	localparam int SCAN_STEP_US     = 500;                    // time per scan step
	localparam int SCAN_STEP_CYC    = CLK_HZ / 1000000 * SCAN_STEP_US; // cycles per step
	localparam int DEBOUNCE_US      = 250;                    // key settle, under one row step
	localparam int DEBOUNCE_CYC     = (CLK_HZ / 1000000) * DEBOUNCE_US;
	localparam int DP_HOLD_MS       = 4;                      // decimal point hold time
	localparam int DP_HOLD_CYC      = (CLK_HZ / 1000) * DP_HOLD_MS;

	// ---------------------------------------------------------------
	// memory map (octal addresses)
	// ---------------------------------------------------------------
	localparam logic [14:0] MEM_BASE     = 15'o77400;         // lowest section address
	localparam logic [14:0] MEM_TOP      = 15'o77777;         // highest section address
	localparam logic [7:0]  RAM_LO       = 8'o160;            // start of ram overlay
	localparam logic [7:0]  RAM_HI       = 8'o177;            // end of ram overlay
	localparam logic [7:0]  DISP_OFS     = 8'o176;            // display word offset
	localparam logic [7:0]  SWITCH_OFS   = 8'o177;            // switches word offset
	localparam int          ROM_WORDS    = 256;               // rom depth
	localparam int          RAM_WORDS    = 16;                // ram depth

	// ---------------------------------------------------------------
	// io field layout
	// ---------------------------------------------------------------
	localparam int SCAN_STEPS   = 6;                          // display digits
	localparam int KEY_ROWS     = 5;                          // keyboard rows
	localparam int KEY_BITS     = 5;                          // key code width
	localparam int FUNC_LSB     = 8;                          // key code at ac bits 3..7
	localparam logic [1:0] FLAG_NONE  = 2'h0;                 // no flag op
	localparam logic [1:0] FLAG_START = 2'h1;                 // s: busy set, done clear
	localparam logic [1:0] FLAG_CLEAR = 2'h2;                 // c: both clear
	localparam logic [1:0] FLAG_PULSE = 2'h3;                 // p: done clear
endpackage

/* hcc_debounce.sv */
/*
 * hcc_debounce: key strobe filter; emits one pulse per settled press.
 * assumes the strobe input is already synchronised to clk.
 */
`timescale 1ns/1ps
module hcc_debounce
	import hcc_pkg::*;
#(
	parameter int SETTLE_CYC = DEBOUNCE_CYC  // cycles a new level must hold
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// strobe
	input  wire logic strobe_in,
	output logic      press_pulse
);
	logic [22:0] cnt_reg;       // settle counter
	logic        stable_reg;    // filtered level

	// ---------------------------------------------------------------
	// filter
	// ---------------------------------------------------------------
	// count while raw differs from filtered level, then flip
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg     <= 23'h0;
			stable_reg  <= 1'b0;
			press_pulse <= 1'b0;
		end else begin
			press_pulse <= 1'b0;
			if (strobe_in == stable_reg) begin
				cnt_reg <= 23'h0;
			end else if (cnt_reg == 23'(SETTLE_CYC - 1)) begin
				cnt_reg     <= 23'h0;
				stable_reg  <= strobe_in;
				press_pulse <= strobe_in; // rising settled edge only
			end else begin
				cnt_reg <= cnt_reg + 23'h1;
			end
		end
	end
endmodule // hcc_debounce

/* hcc_console_asserts.sv */
/* hcc_console_asserts: port-level checks for hcc_console.
 assumes one clock clk and a synchronous active-low rst_n. */
`timescale 1ns/1ps
module hcc_console_asserts
	import hcc_pkg::*;
#(
	parameter int DP_CYC = DP_HOLD_CYC  // decimal point hold cycles
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// io bus
	input wire logic        io_read_a,
	input wire logic        io_read_c,
	input wire logic        io_write_c,
	input wire logic [1:0]  io_flag_op,
	input wire logic [15:0] io_data_in,
	input wire logic        io_data_valid,
	input wire logic        io_busy,
	input wire logic        io_done,
	input wire logic        io_int_req,
	// memory bus
	input wire logic        mem_start,
	input wire logic [14:0] mem_addr,
	input wire logic        mem_read,
	input wire logic        mem_refresh,
	input wire logic        mem_end,
	input wire logic        mem_rdata_oe,
	input wire logic        memory_inhibit_line,
	// display
	input wire logic [2:0]  disp_scan,
	input wire logic [5:0]  disp_cell,
	input wire logic        disp_point
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic        cmd_any;  // any io command this cycle
	logic        hit;      // address inside the section
	int unsigned dp_cnt;   // cycles of point hold seen so far
	assign cmd_any = io_read_a | io_read_c | io_write_c;
	assign hit     = (mem_addr[14:8] == 7'h7F);
	sequence s_rd_take;
		mem_start && mem_read && !mem_refresh && hit;
	endsequence
	sequence s_drive;
		mem_rdata_oe && memory_inhibit_line;
	endsequence
	// point hold counter, restarts on every write command
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dp_cnt <= 0;
		end else if (io_write_c) begin
			dp_cnt <= 1;
		end else if (dp_cnt == 0 || dp_cnt == DP_CYC) begin
			dp_cnt <= 0;
		end else begin
			dp_cnt <= dp_cnt + 1;
		end
	end
	chk_rd_drive: assert property (s_rd_take |-> ##2 s_drive)
		else $error("read hit not driven");
	chk_miss_quiet: assert property ((mem_start && (!hit || mem_refresh || !mem_read))
		|-> ##2 !mem_rdata_oe)
		else $error("bus driven without a read hit");
	chk_inhibit_pair: assert property (memory_inhibit_line == mem_rdata_oe)
		else $error("inhibit differs from data drive");
	chk_end_release: assert property (mem_end |-> ##2 !mem_rdata_oe)
		else $error("drive kept after end");
	chk_io_answer: assert property ((io_read_a || io_read_c) |=> io_data_valid ##1 !io_data_valid)
		else $error("io answer not one pulse");
	chk_func_zero: assert property (io_read_c |=> io_data_in[15:13] == 3'h0
		&& io_data_in[7:0] == 8'h00)
		else $error("function word spare bits set");
	// a key press in the command cycle keeps done set, with its interrupt
	chk_flag_start: assert property (cmd_any && io_flag_op == FLAG_START
		|=> io_busy && (!io_done || io_int_req))
		else $error("start flag op wrong");
	chk_flag_clear: assert property (cmd_any && io_flag_op == FLAG_CLEAR
		|=> !io_busy && (!io_done || io_int_req))
		else $error("clear flag op wrong");
	chk_flag_pulse: assert property (cmd_any && io_flag_op == FLAG_PULSE
		|=> (!io_done || io_int_req) && io_busy == $past(io_busy))
		else $error("pulse flag op wrong");
	chk_point_hold: assert property (disp_point == (dp_cnt != 0))
		else $error("point hold length wrong");
	chk_cell_scan: assert property (disp_cell != 6'h00
		|-> disp_cell == (6'h01 << disp_scan) && disp_scan < 3'h6)
		else $error("cell does not match scan");
	chk_key_int: assert property ($rose(io_done) |-> io_int_req)
		else $error("done without interrupt");
endmodule // hcc_console_asserts

/* hcc_host.sv */
/* hcc_host: behavioural cpu buses and key pad facing hcc_console.
 assumes the console contract: pulses one cycle, rdata two edges on. */
`timescale 1ns/1ps
module hcc_host
	import hcc_pkg::*;
(
	// clock
	input wire logic  clk,
	// io bus
	output logic        io_read_a,
	output logic        io_read_c,
	output logic        io_write_c,
	output logic [1:0]  io_flag_op,
	input wire logic [15:0] io_data_in,
	// memory bus
	output logic        mem_start,
	output logic [14:0] mem_addr,
	output logic        mem_read,
	output logic        mem_write,
	output logic        mem_refresh,
	output logic [15:0] mem_wdata,
	output logic        mem_end,
	input wire logic [15:0] mem_rdata,
	input wire logic    mem_rdata_oe,
	// key pad
	input wire logic [4:0]  key_rows,
	output wire logic [3:0] key_columns_pin,
	output wire logic       key_strobe_pin
);
	logic [3:0] held_cols;  // columns of the key held down
	logic [2:0] held_row;   // row of the key held down
	// a held key closes its column only while its row is driven
	assign key_columns_pin = key_rows[held_row] ? held_cols : 4'h0;
	assign key_strobe_pin  = |key_columns_pin;
	// idle bus at time zero
	initial begin
		{io_read_a, io_read_c, io_write_c, io_flag_op} = 5'h00;
		{mem_start, mem_read, mem_write, mem_refresh, mem_end} = 5'h00;
		mem_addr = 15'h0000;
		mem_wdata = 16'h0000;
		held_cols = 4'h0;
		held_row = 3'h0;
	end
	// one memory operation; rwf is {read, write, refresh}
	task automatic mem_op(input logic [14:0] a, input logic [2:0] rwf,
		input logic [15:0] wd, output logic [15:0] rd, output logic oe);
		@(posedge clk);
		mem_start <= 1'b1;
		mem_addr <= a;
		{mem_read, mem_write, mem_refresh} <= rwf;
		mem_wdata <= wd;
		@(posedge clk);
		mem_start <= 1'b0;
		repeat (2) @(posedge clk);
		rd = mem_rdata;
		oe = mem_rdata_oe;
		mem_end <= 1'b1;
		@(posedge clk);
		mem_end <= 1'b0;
		{mem_read, mem_write, mem_refresh} <= 3'h0;
		mem_addr <= ~mem_addr;   // released lines do not keep old value
		mem_wdata <= ~mem_wdata;
	endtask
	// one io command; kind is {read_a, read_c, write_c}
	task automatic io_cmd(input logic [2:0] kind, input logic [1:0] f,
		output logic [15:0] d);
		@(posedge clk);
		{io_read_a, io_read_c, io_write_c} <= kind;
		io_flag_op <= f;
		@(posedge clk);
		{io_read_a, io_read_c, io_write_c} <= 3'h0;
		io_flag_op <= FLAG_NONE;
		@(posedge clk);
		d = io_data_in;
	endtask
	// press or release keys in the pad
	task automatic key_set(input logic [2:0] row, input logic [3:0] cols);
		@(posedge clk);
		held_row <= row;
		held_cols <= cols;
	endtask
endmodule // hcc_host

/* hcc_console_tb_top.sv */
/* hcc_console_tb_top: self-checking bench for hcc_console.
 assumes hcc_host drives the buses and key pad. */
`timescale 1ns/1ps
module hcc_console_tb_top;
	import hcc_pkg::*;
	logic clk, rst_n, io_read_a, io_read_c, io_write_c, io_data_valid;
	logic io_busy, io_done, io_int_req, mem_start, mem_read, mem_write;
	logic mem_refresh, mem_end, mem_rdata_oe, memory_inhibit_line;
	logic disp_point, key_strobe_pin, oe;
	logic [1:0]  io_flag_op;
	logic [15:0] io_data_in, mem_wdata, mem_rdata, d;
	logic [14:0] mem_addr;
	logic [2:0]  disp_scan;
	logic [6:0]  disp_segments;
	logic [5:0]  disp_cell;
	logic [4:0]  key_rows;
	logic [3:0]  key_columns_pin;
	int err_count, checks_done, i, n;
	hcc_console #(.DP_CYC(50), .STEP_CYC(8), .DEB_CYC(4)) u_dut (.clk, .rst_n,
		.io_read_a, .io_read_c, .io_write_c, .io_flag_op, .io_data_in, .io_data_valid,
		.io_busy, .io_done,
		.io_int_req, .mem_start, .mem_addr, .mem_read, .mem_write, .mem_refresh,
		.mem_wdata, .mem_end, .mem_rdata, .mem_rdata_oe, .memory_inhibit_line,
		.disp_scan, .disp_segments, .disp_cell, .disp_point, .key_rows,
		.key_columns_pin, .key_strobe_pin);
	hcc_host u_host (.clk, .io_read_a, .io_read_c, .io_write_c, .io_flag_op, .io_data_in,
		.mem_start, .mem_addr, .mem_read, .mem_write, .mem_refresh, .mem_wdata,
		.mem_end, .mem_rdata, .mem_rdata_oe, .key_rows, .key_columns_pin, .key_strobe_pin);
	always #12.5 clk = ~clk;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		if (err_count == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// segment pattern gfedcba of one octal digit
	function automatic logic [15:0] seg7(input int v);
		logic [6:0] p[8] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07};
		return {9'h000, p[v]};
	endfunction
	// watchdog over the whole run
	initial begin
		#200000;
		err_count++;
		stop_test();
	end
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		err_count = 0;
		checks_done = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		// fill and read back the ram overlay
		for (i = 0; i < 16; i++) u_host.mem_op(15'(15'o77560 + i), 3'h2, 16'(16'hA000 + i), d, oe);
		for (i = 0; i < 16; i++) begin
			u_host.mem_op(15'(15'o77560 + i), 3'h4, 16'h0000, d, oe);
			chk(d, 16'(16'hA000 + i));
			chk(16'(oe), 16'h0001);
		end
		// rom write ignored, refresh ignored, miss not answered
		u_host.mem_op(15'o77400, 3'h2, 16'hFFFF, d, oe);
		u_host.mem_op(15'o77400, 3'h4, 16'h0000, d, oe);
		chk(d, 16'h0000);
		u_host.mem_op(15'o77562, 3'h3, 16'h5555, d, oe);
		u_host.mem_op(15'o00562, 3'h2, 16'h1234, d, oe);
		u_host.mem_op(15'o00562, 3'h4, 16'h0000, d, oe);
		chk(16'(oe), 16'h0000);
		u_host.mem_op(15'o77562, 3'h4, 16'h0000, d, oe);
		chk(d, 16'hA002);
		// display word shows digits 1..6
		u_host.mem_op(15'o77576, 3'h2, 16'o123456, d, oe);
		repeat (100) @(posedge clk);
		for (i = 0; i < 6; i++) begin
			n = 0;
			while (disp_scan !== 3'(i) && n < 200) begin
				@(posedge clk);
				n++;
			end
			chk(16'(disp_segments), seg7(i + 1));
		end
		// switches word and start flag op
		u_host.io_cmd(3'h4, FLAG_START, d);
		chk(d, 16'hA00F);
		chk(16'({io_busy, io_done}), 16'h0002);
		// key at row 3 column 2, pressed while row 3 is not driven
		while (key_rows[3] === 1'b1) begin
			@(posedge clk);
		end
		u_host.key_set(3'h3, 4'h4);
		n = 0;
		while (io_done !== 1'b1 && n < 500) begin
			@(posedge clk);
			n++;
		end
		chk(16'(io_done), 16'h0001);
		chk(16'(io_int_req), 16'h0001);
		u_host.key_set(3'h0, 4'h0);
		u_host.io_cmd(3'h2, FLAG_PULSE, d);
		chk(16'(d[9:8]), 16'h0002);
		chk(16'(d[12:10]), 16'h0003);
		chk({d[15:13], 5'h00, d[7:0]}, 16'h0000);
		chk(16'({io_busy, io_done}), 16'h0002);
		// decimal point with clear flag op
		u_host.io_cmd(3'h1, FLAG_CLEAR, d);
		chk(16'({io_busy, io_done, io_int_req}), 16'h0000);
		n = 0;
		while (disp_point === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(16'(n), 16'd50);
		stop_test();
	end
endmodule // hcc_console_tb_top
bind hcc_console hcc_console_asserts #(.DP_CYC(DP_CYC)) u_chk (.clk, .rst_n, .io_read_a,
	.io_read_c, .io_write_c, .io_flag_op, .io_data_in, .io_data_valid, .io_busy, .io_done,
	.io_int_req, .mem_start, .mem_addr, .mem_read, .mem_refresh, .mem_end, .mem_rdata_oe,
	.memory_inhibit_line, .disp_scan, .disp_cell, .disp_point);
